// [design/tx_pair_defs.vh]
// Constants for the transmit pair bus capture block.
// Assumes inclusion by bare name from the design files.
`ifndef TX_PAIR_DEFS_VH
`define TX_PAIR_DEFS_VH

// Interface modes
`define MODE_MUX 2'h0
`define MODE_NIBBLE 2'h1
`define MODE_INDEP 2'h2
`define MODE_W 2

// Pair bus shape
`define PAIRS 3
`define BUS_W 10
`define LANE_W 5
`define BYTE_W 8

// Bit positions on a pair bus
`define BIT_KFLAG 8
`define BIT_TENTH 9
`define BIT_KFLAG_EVEN 3
`define LANE_KBIT 3
`define LANE_TOP 4

// FIFO entry: {k_even, word_even, k_odd, word_odd}
`define ENTRY_W 22
`define ENT_ODD_LSB 0
`define ENT_KODD 10
`define ENT_EVEN_LSB 11
`define ENT_KEVEN 21

// Buffering and serializer
`define FIFO_DEPTH 8
`define BIT_CNT_W 4
`define BIT_CNT_LAST 4'h9
`define BIT_CNT_ZERO 4'h0

`endif

// [design/tx_word_fifo.v]
// Word FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module tx_word_fifo
#(
  parameter WIDTH = 22,
  parameter DEPTH = 8,
  parameter AW = 3
)
(
  // Clock and reset
  input wire i_mclk,
  input wire i_reset,
  // Fill side
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_in_ready,
  // Drain side
  output wire o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input wire i_out_ready
);

  // Storage array
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  // Pointers carry one extra wrap bit
  reg [AW:0] wptr_q;
  reg [AW:0] rptr_q;
  wire full;
  wire empty;
  wire push;
  wire pop;

  // Full when indexes meet with opposite wrap bits
  assign full = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  assign empty = (wptr_q == rptr_q);
  assign push = i_in_valid && !full;
  assign pop = i_out_ready && !empty;
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_q[rptr_q[AW-1:0]];

  // Write side
  always @(posedge i_mclk)
  begin
    if (push)
    begin
      mem_q[wptr_q[AW-1:0]] <= i_in_data;
    end
  end

  // Pointer update
  always @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      wptr_q <= {(AW+1){1'b0}};
      rptr_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (pop)
      begin
        rptr_q <= rptr_q + 1'b1;
      end
    end
  end

endmodule // tx_word_fifo

`default_nettype wire

// [design/tx_pair_capture.v]
// What this block does
// - Mux, raw: bit 8 is word bit 8
// - Mux, encoded: bit 8 high marks K-character
// - Nibble, raw: bit 8 carries odd bits 3, 8
// - Nibble, encoded: bit 8 is odd K flag
// - Nibble, encoded: bit 3 is even K flag
// - Raw: bit 9 is word bit 9; in nibble mode it carries odd bits 9, 4
// - Independent mode: each pair uses own clock
// - Other modes: all pairs use shared clock
// - Sample both edges; serialize bit 0 first
// - Mux: odd on rising, even on falling
// - Nibble: MS rising, LS falling; lanes split
//
// Capture of pair buses C/D, E/F, G/H, with FIFO and bit serializer.
// Assumes link clocks and buses come from outside i_mclk; mode and
// encoder enable are static straps from logic on i_mclk.
`timescale 1ns/100ps
`default_nettype none
`include "tx_pair_defs.vh"

module tx_pair_capture
#(
  parameter FIFO_DEPTH = `FIFO_DEPTH,
  parameter FIFO_AW = 3
)
(
  // Clock and reset
  input wire i_mclk,
  input wire i_reset,
  // Configuration
  input wire [`MODE_W-1:0] i_mode,
  input wire i_encode_en,
  // Link clocks
  input wire i_shared_tx_clock,
  input wire i_pair_cd_tx_clock,
  input wire i_pair_ef_tx_clock,
  input wire i_pair_gh_tx_clock,
  // Pair buses
  input wire [`BUS_W-1:0] i_tx_bus_pair_cd,
  input wire [`BUS_W-1:0] i_tx_bus_pair_ef,
  input wire [`BUS_W-1:0] i_tx_bus_pair_gh,
  // Serial outputs, one even and one odd per pair
  output reg [`PAIRS-1:0] o_ser_even,
  output reg [`PAIRS-1:0] o_ser_odd,
  output reg [`PAIRS-1:0] o_ser_active,
  output reg [`PAIRS-1:0] o_ser_first,
  // K flags and encoder steering, held for a word
  output reg [`PAIRS-1:0] o_k_even,
  output reg [`PAIRS-1:0] o_k_odd,
  output reg [`PAIRS-1:0] o_to_encoder,
  // Sticky overflow per pair
  output reg [`PAIRS-1:0] o_overflow
);

  // Synchronizer stages for the four clocks and three buses
  reg [3:0] clk_s1_q;
  reg [3:0] clk_s2_q;
  reg [3:0] clk_s3_q;
  reg [`PAIRS*`BUS_W-1:0] bus_s1_q;
  reg [`PAIRS*`BUS_W-1:0] bus_s2_q;
  reg [`PAIRS*`BUS_W-1:0] bus_s3_q;
  wire [3:0] clk_raw;
  wire [`PAIRS*`BUS_W-1:0] bus_raw;

  assign clk_raw = {i_pair_gh_tx_clock, i_pair_ef_tx_clock, i_pair_cd_tx_clock,
                    i_shared_tx_clock};
  assign bus_raw = {i_tx_bus_pair_gh, i_tx_bus_pair_ef, i_tx_bus_pair_cd};

  // Three-stage synchronizers; only stage 1 feeds stage 2
  always @(posedge i_mclk)
  begin
    clk_s1_q <= clk_raw;
    clk_s2_q <= clk_s1_q;
    clk_s3_q <= clk_s2_q;
    bus_s1_q <= bus_raw;
    bus_s2_q <= bus_s1_q;
    bus_s3_q <= bus_s2_q;
  end

  genvar p;
  generate
    for (p = 0; p < `PAIRS; p = p + 1)
    begin : g_pair
      // Selected clock stages and filtered level
      wire sel_s2;
      wire sel_s3;
      wire settled;
      wire rise;
      wire fall;
      wire [`BUS_W-1:0] bus;
      wire [`LANE_W-1:0] lane_even;
      wire [`LANE_W-1:0] lane_odd;
      reg lvl_q;
      // Rising-edge half: odd word in mux, MS lanes in nibble
      reg [`LANE_W-1:0] ms_even_q;
      reg [`LANE_W-1:0] ms_odd_q;
      reg [`BUS_W-1:0] odd_word_q;
      reg odd_k_q;
      reg have_rise_q;
      // Assembled entry and push request
      reg [`ENTRY_W-1:0] entry_d;
      reg [`BUS_W-1:0] even_w;
      reg [`BUS_W-1:0] odd_w;
      reg even_k;
      reg odd_k;
      reg push_q;
      reg [`ENTRY_W-1:0] entry_q;
      wire in_ready;
      wire out_valid;
      wire [`ENTRY_W-1:0] out_data;
      // Serializer state
      reg [`BUS_W-1:0] sh_even_q;
      reg [`BUS_W-1:0] sh_odd_q;
      reg [`BIT_CNT_W-1:0] cnt_q;
      reg busy_q;
      wire take;

      // Pair clock only in independent mode, else the shared one
      assign sel_s2 = (i_mode == `MODE_INDEP) ? clk_s2_q[p+1] : clk_s2_q[0];
      assign sel_s3 = (i_mode == `MODE_INDEP) ? clk_s3_q[p+1] : clk_s3_q[0];
      // A level change counts once stages 2 and 3 agree
      assign settled = (sel_s2 == sel_s3);
      assign rise = settled && sel_s3 && !lvl_q;
      assign fall = settled && !sel_s3 && lvl_q;
      assign bus = bus_s3_q[p*`BUS_W +: `BUS_W];
      assign lane_even = bus[`LANE_W-1:0];
      assign lane_odd = bus[`BUS_W-1:`LANE_W];

      // Edge tracking and rising-edge capture
      always @(posedge i_mclk)
      begin
        if (i_reset)
        begin
          lvl_q <= 1'b0;
          have_rise_q <= 1'b0;
          ms_even_q <= {`LANE_W{1'b0}};
          ms_odd_q <= {`LANE_W{1'b0}};
          odd_word_q <= {`BUS_W{1'b0}};
          odd_k_q <= 1'b0;
        end
        else
        begin
          if (settled)
          begin
            lvl_q <= sel_s3;
          end
          if (rise)
          begin
            // Odd channel on rising edge, MS nibbles in nibble mode
            have_rise_q <= 1'b1;
            ms_even_q <= lane_even;
            ms_odd_q <= lane_odd;
            if (i_encode_en)
            begin
              // Bit 9 dropped; bit 8 is K
              odd_word_q <= {{(`BUS_W-`BYTE_W){1'b0}}, bus[`BYTE_W-1:0]};
              odd_k_q <= bus[`BIT_KFLAG];
            end
            else
            begin
              odd_word_q <= bus;
              odd_k_q <= 1'b0;
            end
          end
          else if (fall)
          begin
            have_rise_q <= 1'b0;
          end
        end
      end

      // Word assembly on the falling edge
      always @*
      begin
        even_w = {`BUS_W{1'b0}};
        odd_w = {`BUS_W{1'b0}};
        even_k = 1'b0;
        odd_k = 1'b0;
        if (i_mode == `MODE_NIBBLE)
        begin
          if (i_encode_en)
          begin
            // Lane bit 3 is K on rising edge, data on falling edge
            even_w = {2'b00, ms_even_q[`LANE_TOP], ms_even_q[2:0], lane_even[3:0]};
            odd_w = {2'b00, ms_odd_q[`LANE_TOP], ms_odd_q[2:0], lane_odd[3:0]};
            even_k = ms_even_q[`LANE_KBIT];
            odd_k = ms_odd_q[`LANE_KBIT];
          end
          else
          begin
            // MS lane on rising, LS lane on falling; bus bit 8 lands in bits 8 and 3
            even_w = {ms_even_q, lane_even};
            odd_w = {ms_odd_q, lane_odd};
          end
        end
        else
        begin
          // Mux framing: even word on the falling edge
          odd_w = odd_word_q;
          odd_k = odd_k_q;
          if (i_encode_en)
          begin
            even_w = {{(`BUS_W-`BYTE_W){1'b0}}, bus[`BYTE_W-1:0]};
            even_k = bus[`BIT_KFLAG];
          end
          else
          begin
            even_w = bus;
          end
        end
        entry_d = {even_k, even_w, odd_k, odd_w};
      end

      // Push a word pair once both halves are in
      always @(posedge i_mclk)
      begin
        if (i_reset)
        begin
          push_q <= 1'b0;
          entry_q <= {`ENTRY_W{1'b0}};
          o_overflow[p] <= 1'b0;
        end
        else
        begin
          push_q <= fall && have_rise_q;
          if (fall && have_rise_q)
          begin
            entry_q <= entry_d;
          end
          // Dropped pair when the FIFO is full
          if (push_q && !in_ready)
          begin
            o_overflow[p] <= 1'b1;
          end
        end
      end

      tx_word_fifo
      #(
        .WIDTH(`ENTRY_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
      )
      u_fifo
      (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_in_valid(push_q),
        .i_in_data(entry_q),
        .o_in_ready(in_ready),
        .o_out_valid(out_valid),
        .o_out_data(out_data),
        .i_out_ready(take)
      );

      // Take a new entry when the shifter is idle or on its last bit
      assign take = out_valid && (!busy_q || (cnt_q == `BIT_CNT_LAST));

      // Serializer, bit 0 first
      always @(posedge i_mclk)
      begin
        if (i_reset)
        begin
          busy_q <= 1'b0;
          cnt_q <= `BIT_CNT_ZERO;
          sh_even_q <= {`BUS_W{1'b0}};
          sh_odd_q <= {`BUS_W{1'b0}};
          o_ser_even[p] <= 1'b0;
          o_ser_odd[p] <= 1'b0;
          o_ser_active[p] <= 1'b0;
          o_ser_first[p] <= 1'b0;
          o_k_even[p] <= 1'b0;
          o_k_odd[p] <= 1'b0;
          o_to_encoder[p] <= 1'b0;
        end
        else if (take)
        begin
          // Load: bit 0 goes out now, rest shifts down
          busy_q <= 1'b1;
          cnt_q <= `BIT_CNT_ZERO;
          sh_even_q <= out_data[`ENT_EVEN_LSB +: `BUS_W] >> 1;
          sh_odd_q <= out_data[`ENT_ODD_LSB +: `BUS_W] >> 1;
          o_ser_even[p] <= out_data[`ENT_EVEN_LSB];
          o_ser_odd[p] <= out_data[`ENT_ODD_LSB];
          o_ser_active[p] <= 1'b1;
          o_ser_first[p] <= 1'b1;
          o_k_even[p] <= out_data[`ENT_KEVEN];
          o_k_odd[p] <= out_data[`ENT_KODD];
          o_to_encoder[p] <= i_encode_en;
        end
        else if (busy_q && (cnt_q != `BIT_CNT_LAST))
        begin
          cnt_q <= cnt_q + 1'b1;
          sh_even_q <= sh_even_q >> 1;
          sh_odd_q <= sh_odd_q >> 1;
          o_ser_even[p] <= sh_even_q[0];
          o_ser_odd[p] <= sh_odd_q[0];
          o_ser_first[p] <= 1'b0;
        end
        else
        begin
          // Idle after last bit
          busy_q <= 1'b0;
          o_ser_active[p] <= 1'b0;
          o_ser_first[p] <= 1'b0;
          o_ser_even[p] <= 1'b0;
          o_ser_odd[p] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule // tx_pair_capture

`default_nettype wire

// [bench/tx_pair_capture_monitor.sv]
// Checker on the capture block ports, watching the C/D lane.
// Assumes one clock domain; bound from the bench top.
`timescale 1ns/100ps
`default_nettype none
module tx_pair_capture_monitor
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Watched signals
  input wire logic i_encode_en,
  input wire logic [2:0] o_ser_even,
  input wire logic [2:0] o_ser_odd,
  input wire logic [2:0] o_ser_active,
  input wire logic [2:0] o_ser_first,
  input wire logic [2:0] o_k_even,
  input wire logic [2:0] o_to_encoder
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // A word shifts for ten cycles
  property p_word_len;
    o_ser_first[0] |-> o_ser_active[0] [*8] ##1 o_ser_active[0] [*2];
  endproperty
  a_word_len: assert property (p_word_len) else $error("word too short");
  // No new word inside ten cycles
  property p_gap;
    o_ser_first[0] |=> !o_ser_first[0] [*8] ##1 !o_ser_first[0];
  endproperty
  a_gap: assert property (p_gap) else $error("word restarted early");
  // Shifting starts with bit zero
  property p_start;
    $rose(o_ser_active[0]) |-> o_ser_first[0];
  endproperty
  a_start: assert property (p_start) else $error("start without first bit");
  // Steering holds for the word
  property p_enc_hold;
    o_ser_active[0] && !o_ser_first[0] |-> $stable(o_to_encoder[0]);
  endproperty
  a_enc_hold: assert property (p_enc_hold) else $error("steering moved");
  // K flag holds for the word
  property p_k_hold;
    o_ser_active[0] && !o_ser_first[0] |-> $stable(o_k_even[0]);
  endproperty
  a_k_hold: assert property (p_k_hold) else $error("k flag moved");
  // Raw words carry no K flag and skip the encoder
  property p_raw_flags;
    o_ser_active[0] && !i_encode_en |-> !o_k_even[0] && !o_to_encoder[0];
  endproperty
  a_raw_flags: assert property (p_raw_flags) else $error("raw word flagged");
  // Encoded words go to the encoder
  property p_enc_flag;
    o_ser_active[0] && i_encode_en |-> o_to_encoder[0];
  endproperty
  a_enc_flag: assert property (p_enc_flag) else $error("byte not steered");
  // Encoded words have zero top bits
  property p_top_zero;
    o_ser_first[0] && i_encode_en |-> ##8 !(o_ser_even[0] | o_ser_odd[0]) [*2];
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("top bits set");
endmodule // tx_pair_capture_monitor
`default_nettype wire

// [bench/tx_link_partner.sv]
// Protocol device model driving link clocks and pair buses.
// Assumes the caller starts a frame off the mclk rising edge.
`timescale 1ns/100ps
`default_nettype none
module tx_link_partner
(
  // Link clocks, low between frames
  output var logic o_shared_clk,
  output var logic o_cd_clk,
  output var logic o_ef_clk,
  output var logic o_gh_clk,
  // Buses {gh, ef, cd}
  output var logic [29:0] o_bus
);
  initial
  begin
    {o_gh_clk, o_ef_clk, o_cd_clk, o_shared_clk} = 4'h0;
    o_bus = 30'h0;
  end
  // One 125 ns frame: rising half then falling half
  task automatic send(input logic [3:0] sel, input logic [29:0] r, input logic [29:0] f);
    o_bus = r;
    #31 {o_gh_clk, o_ef_clk, o_cd_clk, o_shared_clk} = sel;
    #31 o_bus = f;
    #31 {o_gh_clk, o_ef_clk, o_cd_clk, o_shared_clk} = 4'h0;
    // Hold time over: bit 9 of each bus falls to its pull-down, the rest show the inverse
    #16 o_bus = ~f & 30'h1FF7FDFF;
    // Quiet tail keeps the frame at 125 ns, so a next frame never drives twice at once
    #16;
  endtask
endmodule // tx_link_partner
`default_nettype wire

// [bench/tx_pair_capture_tb.sv]
// Self-checking bench for the pair bus capture block and its FIFO.
// Assumes the partner model and the bound checker beside it.
`timescale 1ns/100ps
`default_nettype none
`include "tx_pair_defs.vh"
module tx_pair_capture_tb;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic [1:0] i_mode = 2'h0;
  logic i_encode_en = 1'b0;
  wire logic sclk, cclk, eclk, gclk;
  wire logic [29:0] bus;
  wire logic [2:0] ser_e, ser_o, act, fst, ke, ko, enc, ovf;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [9:0] ge [3];
  logic [9:0] go [3];
  logic [2:0] seen, gke, gko, genc;
  tx_link_partner i_tx_link_partner (.o_shared_clk(sclk), .o_cd_clk(cclk),
    .o_ef_clk(eclk), .o_gh_clk(gclk), .o_bus(bus));
  tx_pair_capture i_tx_pair_capture (.i_mclk(i_mclk), .i_reset(i_reset), .i_mode(i_mode),
    .i_encode_en(i_encode_en), .i_shared_tx_clock(sclk), .i_pair_cd_tx_clock(cclk),
    .i_pair_ef_tx_clock(eclk), .i_pair_gh_tx_clock(gclk), .i_tx_bus_pair_cd(bus[9:0]),
    .i_tx_bus_pair_ef(bus[19:10]), .i_tx_bus_pair_gh(bus[29:20]), .o_ser_even(ser_e),
    .o_ser_odd(ser_o), .o_ser_active(act), .o_ser_first(fst), .o_k_even(ke), .o_k_odd(ko),
    .o_to_encoder(enc), .o_overflow(ovf));
  // 200 MHz clock
  initial
    forever #2.5 i_mclk = ~i_mclk;
  // Hang guard
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      $display("mismatch at %0t: timeout", $time);
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk10(input logic [9:0] g, input logic [9:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch at %0t: word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk3(input logic [2:0] g, input logic [2:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch at %0t: flags %b expected %b", $time, g, e);
    end
  endtask
  // Straps change only under reset
  task automatic rst(input logic [1:0] m, input logic en);
    i_reset = 1'b1;
    i_mode = m;
    i_encode_en = en;
    repeat (2) @(negedge i_mclk);
    i_reset = 1'b0;
    repeat (4) @(negedge i_mclk);
  endtask
  // Gathers ten serial bits per pair from its first-bit pulse
  task automatic collect(input int cycles);
    int idx [3];
    idx = '{10, 10, 10};
    {seen, gke, gko, genc} = 12'h000;
    repeat (cycles)
    begin
      @(negedge i_mclk);
      for (int p = 0; p < 3; p++)
      begin
        if (fst[p] === 1'b1)
        begin
          idx[p] = 0;
          seen[p] = 1'b1;
          gke[p] = ke[p];
          gko[p] = ko[p];
          genc[p] = enc[p];
        end
        if (idx[p] < 10)
        begin
          ge[p][idx[p]] = ser_e[p];
          go[p][idx[p]] = ser_o[p];
          idx[p]++;
        end
      end
    end
  endtask
  // Expected {k, word} of one channel
  function automatic logic [10:0] exp_word(input logic [1:0] m, input logic en,
    input logic [9:0] rb, input logic [9:0] fb, input logic odd);
    logic [4:0] rl, fl;
    rl = odd ? rb[9:5] : rb[4:0];
    fl = odd ? fb[9:5] : fb[4:0];
    if (m == `MODE_NIBBLE)
      return en ? {rl[3], 2'b00, rl[4], rl[2:0], fl[3:0]} : {1'b0, rl, fl};
    rb = odd ? rb : fb;
    return en ? {rb[8], 2'b00, rb[7:0]} : {1'b0, rb};
  endfunction
  // Judges the gathered words and flags of one frame against the rules
  task automatic judge(input logic [1:0] m, input logic en, input logic [29:0] r,
    input logic [29:0] f, input logic [2:0] s);
    logic [10:0] xe, xo;
    logic [2:0] eke, eko;
    chk3(seen, s);
    {eke, eko} = 6'h00;
    for (int p = 0; p < 3; p++)
    begin
      xe = exp_word(m, en, r[p*10+:10], f[p*10+:10], 1'b0);
      xo = exp_word(m, en, r[p*10+:10], f[p*10+:10], 1'b1);
      eke[p] = xe[10] & s[p];
      eko[p] = xo[10] & s[p];
      if (s[p])
      begin
        chk10(ge[p], xe[9:0]);
        chk10(go[p], xo[9:0]);
      end
    end
    chk3(gke, eke);
    chk3(gko, eko);
    chk3(genc, en ? s : 3'h0);
  endtask
  // One frame after a fresh reset with the given straps
  task automatic run_frame(input logic [1:0] m, input logic en, input logic [3:0] sel,
    input logic [29:0] r, input logic [29:0] f, input logic [2:0] s);
    rst(m, en);
    fork
      i_tx_link_partner.send(sel, r, f);
      collect(60);
    join
    judge(m, en, r, f, s);
    $display("test done: mode %0d encode %0d clocks %h", m, en, sel);
  endtask
  // Two frames back to back pass the word FIFO in order, with no overflow
  task automatic t_stream();
    rst(`MODE_MUX, 1'b0);
    fork
      begin
        i_tx_link_partner.send(4'h1, {10'h2A7, 10'h0D3, 10'h158}, {10'h36C, 10'h0E9, 10'h21B});
        i_tx_link_partner.send(4'h1, {10'h1F4, 10'h32E, 10'h085}, {10'h0BA, 10'h2D1, 10'h347});
      end
      begin
        // First word shifts near cycle 25, second near cycle 50
        collect(40);
        judge(`MODE_MUX, 1'b0, {10'h2A7, 10'h0D3, 10'h158},
          {10'h36C, 10'h0E9, 10'h21B}, 3'h7);
        collect(40);
        judge(`MODE_MUX, 1'b0, {10'h1F4, 10'h32E, 10'h085},
          {10'h0BA, 10'h2D1, 10'h347}, 3'h7);
      end
    join
    chk3(ovf, 3'h0);
    chk3(act, 3'h0);
    $display("test done: back-to-back frames through the FIFO");
  endtask
  initial
  begin
    repeat (20) @(negedge i_mclk);
    run_frame(`MODE_MUX, 1'b0, 4'h1, {10'h3A5, 10'h1C3, 10'h2F0},
      {10'h15C, 10'h30F, 10'h0AA}, 3'h7);
    run_frame(`MODE_MUX, 1'b1, 4'h1, {10'h1BC, 10'h0F7, 10'h13C},
      {10'h05A, 10'h1FE, 10'h0C5}, 3'h7);
    run_frame(`MODE_NIBBLE, 1'b0, 4'h1, {10'h2D6, 10'h119, 10'h3E1},
      {10'h0B4, 10'h36A, 10'h18F}, 3'h7);
    run_frame(`MODE_NIBBLE, 1'b1, 4'h1, {10'h10B, 10'h0E4, 10'h0F8},
      {10'h06F, 10'h1A3, 10'h1C5}, 3'h7);
    run_frame(`MODE_INDEP, 1'b0, 4'h2, {10'h3C3, 10'h0F0, 10'h1A6},
      {10'h259, 10'h33C, 10'h0E1}, 3'h1);
    run_frame(`MODE_INDEP, 1'b0, 4'h8, {10'h1E7, 10'h2B2, 10'h0D4},
      {10'h34B, 10'h096, 10'h3F2}, 3'h4);
    run_frame(`MODE_INDEP, 1'b0, 4'h1, {10'h155, 10'h2AA, 10'h0FF},
      {10'h300, 10'h0CC, 10'h133}, 3'h0);
    run_frame(`MODE_MUX, 1'b0, 4'hE, {10'h2C9, 10'h117, 10'h3A0},
      {10'h05F, 10'h261, 10'h1B8}, 3'h0);
    chk3(ovf, 3'h0);
    t_stream();
    tally_and_finish();
  end
endmodule // tx_pair_capture_tb
bind tx_pair_capture tx_pair_capture_monitor i_tx_pair_capture_monitor (.i_mclk(i_mclk),
  .i_reset(i_reset), .i_encode_en(i_encode_en), .o_ser_even(o_ser_even),
  .o_ser_odd(o_ser_odd), .o_ser_active(o_ser_active), .o_ser_first(o_ser_first),
  .o_k_even(o_k_even), .o_to_encoder(o_to_encoder));
`default_nettype wire
